/* File: dv/core_model.sv */
// Behavioural processor core that vectors into high or low service
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input  wire logic sys_clk,      // System clock
  input  wire logic rst_b,        // Async reset, active low
  input  wire logic irq_high,     // High request from the bank
  input  wire logic irq_low,      // Low request from the bank
  input  wire logic take,         // Vector to the pending request
  input  wire logic leave,        // Return from every routine
  output logic      in_high_isr,  // Serving a high routine
  output logic      in_low_isr    // Serving a low routine
);
  // High wins when vectoring; a high entry may nest inside low service
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_high_isr <= 1'b0;
      in_low_isr  <= 1'b0;
    end else if (leave) begin
      in_high_isr <= 1'b0;
      in_low_isr  <= 1'b0;
    end else if (take && irq_high) begin
      in_high_isr <= 1'b1;
    end else if (take && irq_low) begin
      in_low_isr <= 1'b1;
    end
  end
endmodule // core_model
`default_nettype wire

/* File: dv/test_irq_bank2.sv */
// Self-checking testbench for the second extended interrupt bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module test_irq_bank2
  import irq_bank2_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst_b   = 1'b0;
  sfr_req_s   req     = '0;
  src_flags_s fl      = '0;
  logic       take    = 1'b0;
  logic       leave   = 1'b0;
  logic       hi_isr, lo_isr, irq_high, irq_low, hit;
  logic [7:0] rdata, src, b;
  int         fails       = 0;
  int         checks_done = 0;
  int         srcs[6]     = '{6, 5, 4, 2, 1, 0};

  irq_bank2 dut (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_req(req), .sfr_rdata(rdata),
    .sfr_hit(hit), .flags(fl), .in_high_isr(hi_isr), .in_low_isr(lo_isr),
    .irq_high(irq_high), .irq_low(irq_low), .irq_src(src));
  core_model core (.sys_clk(sys_clk), .rst_b(rst_b), .irq_high(irq_high),
    .irq_low(irq_low), .take(take), .leave(leave), .in_high_isr(hi_isr),
    .in_low_isr(lo_isr));

  // ---------------------------------------------------------------
  // Access tasks, all driven from the falling edge
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge sys_clk);
    req.wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge sys_clk);
    `CHK(hit, (a == ADDR_IRQ_EN2) || (a == ADDR_IRQ_PRIO2))
    req.rd = 1'b0;
    `CHK(rdata, e)
  endtask

  // Requests are registered, so give the cause two edges to land
  task automatic irq_chk(input logic h, input logic l, input logic [7:0] s);
    repeat (2) @(negedge sys_clk);
    `CHK({irq_high, irq_low, src}, {h, l, s})
  endtask

  // One-cycle command to the core model
  task automatic core_cmd(input logic enter);
    take = enter;
    leave = !enter;
    @(negedge sys_clk);
    take = 1'b0;
    leave = 1'b0;
  endtask

  task automatic test_done();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always #2 sys_clk = ~sys_clk;

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #20000;
    fails++;
    test_done();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    rd_chk(ADDR_IRQ_EN2, 8'h00_00);
    rd_chk(ADDR_IRQ_PRIO2, 8'h00_00);
    wr(ADDR_IRQ_EN2, 8'h00_FF);
    wr(ADDR_IRQ_PRIO2, 8'h00_FF);
    wr(8'h00_E6, 8'h00_FF);
    rd_chk(ADDR_IRQ_EN2, 8'h00_77);
    rd_chk(ADDR_IRQ_PRIO2, 8'h00_77);
    rd_chk(8'h00_E6, 8'h00_00);
    // Each source alone: masked, low, then high; unused flag bits stay up
    foreach (srcs[i]) begin
      b = 8'h00_01 << srcs[i];
      wr(ADDR_IRQ_PRIO2, 8'h00_00);
      wr(ADDR_IRQ_EN2, ~b);
      fl = b | 8'h00_88;
      irq_chk(1'b0, 1'b0, 8'h00_00);
      wr(ADDR_IRQ_EN2, b);
      irq_chk(1'b0, 1'b1, b);
      wr(ADDR_IRQ_PRIO2, b);
      irq_chk(1'b1, 1'b0, b);
      fl = 8'h00_00;
    end
    // High source on bit 6 must beat a low source on the favoured bit 0
    wr(ADDR_IRQ_EN2, 8'h00_77);
    wr(ADDR_IRQ_PRIO2, 8'h00_40);
    fl = 8'h00_41;
    irq_chk(1'b1, 1'b0, 8'h00_40);
    fl = 8'h00_01;
    irq_chk(1'b0, 1'b1, 8'h00_01);
    core_cmd(1'b1);
    irq_chk(1'b0, 1'b0, 8'h00_00);
    fl = 8'h00_41;
    irq_chk(1'b1, 1'b0, 8'h00_40);
    core_cmd(1'b1);
    irq_chk(1'b0, 1'b0, 8'h00_00);
    core_cmd(1'b0);
    irq_chk(1'b1, 1'b0, 8'h00_40);
    test_done();
  end
endmodule // test_irq_bank2
`default_nettype wire

/* File: verilog/irq_bank2.sv */
// Second extended interrupt enable and priority bank
`timescale 1ns/1ns
`default_nettype none
module irq_bank2
  import irq_bank2_pkg::*;
(
  input  wire logic       sys_clk,       // System clock, 250 MHz
  input  wire logic       rst_b,         // Async reset, active low
  input  wire sfr_req_s   sfr_req,       // Register access strobes
  output logic      [7:0] sfr_rdata,     // Read data, registered
  output logic            sfr_hit,       // Address decodes to this bank
  input  wire src_flags_s flags,         // Peripheral event flags, levels
  input  wire logic       in_high_isr,   // Core is serving a high routine
  input  wire logic       in_low_isr,    // Core is serving a low routine
  output logic            irq_high,      // High-level request to core
  output logic            irq_low,       // Low-level request to core
  output logic      [7:0] irq_src        // One-hot source being presented
);
  // -------------------------------------------------------------
  // Register state
  // -------------------------------------------------------------
  logic [7:0] irq_en_r, irq_en_nxt;
  logic [7:0] irq_prio_r, irq_prio_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] src_r, src_nxt;
  logic       high_r, high_nxt;
  logic       low_r, low_nxt;
  logic [7:0] masked, high_req, low_req;
  logic       hit_en, hit_prio;

  // Address decode ignores page selection entirely
  assign hit_en   = (sfr_req.addr == ADDR_IRQ_EN2);
  assign hit_prio = (sfr_req.addr == ADDR_IRQ_PRIO2);
  assign sfr_hit  = hit_en | hit_prio;

  // Writes keep only implemented bits; unused stay zero forever
  always_comb begin
    irq_en_nxt   = irq_en_r;
    irq_prio_nxt = irq_prio_r;
    rdata_nxt    = rdata_r;
    if (sfr_req.wr && hit_en) begin
      irq_en_nxt = sfr_req.wdata & IMPL_MASK;
    end
    if (sfr_req.wr && hit_prio) begin
      irq_prio_nxt = sfr_req.wdata & IMPL_MASK;
    end
    if (sfr_req.rd) begin
      if (hit_en) begin
        rdata_nxt = irq_en_r & IMPL_MASK;
      end else if (hit_prio) begin
        rdata_nxt = irq_prio_r & IMPL_MASK;
      end else begin
        rdata_nxt = 8'h00_00;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_r   <= RESET_VAL;
      irq_prio_r <= RESET_VAL;
      rdata_r    <= RESET_VAL;
    end else begin
      irq_en_r   <= irq_en_nxt;
      irq_prio_r <= irq_prio_nxt;
      rdata_r    <= rdata_nxt;
    end
  end
  assign sfr_rdata = rdata_r;

  // -------------------------------------------------------------
  // Masking and level split
  // -------------------------------------------------------------
  // Each flag passes only when its enable bit is 1
  assign masked = flags & irq_en_r & IMPL_MASK;

  irq_prio_split u_split (
    .masked_req (masked),
    .prio       (irq_prio_r),
    .high_req   (high_req),
    .low_req    (low_req)
  );

  // -------------------------------------------------------------
  // Presentation to the core
  // -------------------------------------------------------------
  // High wins; low is held off while any high is pending or being served.
  // Lowest bit number wins within a level, matching fixed poll order.
  always_comb begin
    high_nxt = 1'b0;
    low_nxt  = 1'b0;
    src_nxt  = 8'h00_00;
    if (|high_req && !in_high_isr) begin
      high_nxt = 1'b1;
      src_nxt  = high_req & (~high_req + 8'h00_01);
    end else if (|low_req && !in_high_isr && !in_low_isr && !(|high_req)) begin
      low_nxt  = 1'b1;
      src_nxt  = low_req & (~low_req + 8'h00_01);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      high_r <= 1'b0;
      low_r  <= 1'b0;
      src_r  <= 8'h00_00;
    end else begin
      high_r <= high_nxt;
      low_r  <= low_nxt;
      src_r  <= src_nxt;
    end
  end
  assign irq_high = high_r;
  assign irq_low  = low_r;
  assign irq_src  = src_r;

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  property p_unused_zero;
    @(posedge sys_clk) disable iff (!rst_b)
      (irq_en_r[7] == 1'b0) && (irq_en_r[3] == 1'b0)
      && (irq_prio_r[7] == 1'b0) && (irq_prio_r[3] == 1'b0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

  property p_en_write;
    @(posedge sys_clk) disable iff (!rst_b)
      (sfr_req.wr && sfr_req.addr == 8'h00_E7) |=> (irq_en_r == ($past(sfr_req.wdata) & 8'h00_77));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost");

  property p_scan_end_mask;
    @(posedge sys_clk) disable iff (!rst_b)
      (!irq_en_r[6]) |-> !masked[6];
  endproperty
  a_scan_end_mask: assert property (p_scan_end_mask) else $error("scan-end leaked");

  property p_cmp_mask;
    @(posedge sys_clk) disable iff (!rst_b)
      (flags.cap_compare_flag && irq_en_r[5]) |-> masked[5];
  endproperty
  a_cmp_mask: assert property (p_cmp_mask) else $error("comparator lost");

  property p_done_mask;
    @(posedge sys_clk) disable iff (!rst_b)
      masked[4] == (flags.cap_done_flag & irq_en_r[4]);
  endproperty
  a_done_mask: assert property (p_done_mask) else $error("done mask wrong");

  property p_rtc_high;
    @(posedge sys_clk) disable iff (!rst_b)
      (flags.rtc_osc_fail_flag && irq_en_r[2] && irq_prio_r[2] && !in_high_isr)
      |=> irq_high;
  endproperty
  a_rtc_high: assert property (p_rtc_high) else $error("osc-fail not high");

  property p_match_low;
    @(posedge sys_clk) disable iff (!rst_b)
      (masked == 8'h00_02 && !irq_prio_r[1] && !in_high_isr && !in_low_isr)
      |=> (irq_low && !irq_high && irq_src == 8'h00_02);
  endproperty
  a_match_low: assert property (p_match_low) else $error("port match not low");

  property p_supply_off;
    @(posedge sys_clk) disable iff (!rst_b)
      (!irq_en_r[0]) |=> (irq_src[0] == 1'b0) or $past(irq_en_r[0]);
  endproperty
  a_supply_off: assert property (p_supply_off) else $error("supply leaked");

  property p_high_first;
    @(posedge sys_clk) disable iff (!rst_b)
      (|high_req) |=> !irq_low;
  endproperty
  a_high_first: assert property (p_high_first) else $error("low beat high");

  // Scan-end flag must reach the split while its enable is set
  property p_scan_end_pass;
    @(posedge sys_clk) disable iff (!rst_b)
      (flags.scan_end_flag && irq_en_r[6]) |-> masked[6];
  endproperty
  a_scan_end_pass: assert property (p_scan_end_pass) else $error("scan-end lost");

  // Comparator flag is blocked while its enable is clear
  property p_cmp_block;
    @(posedge sys_clk) disable iff (!rst_b)
      (!irq_en_r[5]) |-> !masked[5];
  endproperty
  a_cmp_block: assert property (p_cmp_block) else $error("comparator leaked");

  // Oscillator-fail request follows flag and enable exactly
  property p_rtc_mask;
    @(posedge sys_clk) disable iff (!rst_b)
      masked[2] == (flags.rtc_osc_fail_flag & irq_en_r[2]);
  endproperty
  a_rtc_mask: assert property (p_rtc_mask) else $error("osc-fail mask wrong");

  // Port-match request follows flag and enable exactly
  property p_match_mask;
    @(posedge sys_clk) disable iff (!rst_b)
      masked[1] == (flags.pin_match_flag & irq_en_r[1]);
  endproperty
  a_match_mask: assert property (p_match_mask) else $error("match mask wrong");

  // Supply-warning request follows flag and enable exactly
  property p_supply_mask;
    @(posedge sys_clk) disable iff (!rst_b)
      masked[0] == (flags.supply_warn_flag & irq_en_r[0]);
  endproperty
  a_supply_mask: assert property (p_supply_mask) else $error("supply mask wrong");

  // Flags on the unused positions never become requests
  property p_unused_masked;
    @(posedge sys_clk) disable iff (!rst_b)
      (masked[7] == 1'b0) && (masked[3] == 1'b0);
  endproperty
  a_unused_masked: assert property (p_unused_masked) else $error("unused request");

  // Priority write lands with the unused bits dropped
  property p_prio_write;
    @(posedge sys_clk) disable iff (!rst_b)
      (sfr_req.wr && sfr_req.addr == ADDR_IRQ_PRIO2)
      |=> (irq_prio_r == ($past(sfr_req.wdata) & IMPL_MASK));
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority write lost");

  // Enable read returns the value held at the read edge
  property p_rd_en;
    @(posedge sys_clk) disable iff (!rst_b)
      (sfr_req.rd && sfr_req.addr == ADDR_IRQ_EN2) |=> (sfr_rdata == $past(irq_en_r));
  endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable read wrong");

  // Priority read returns the value held at the read edge
  property p_rd_prio;
    @(posedge sys_clk) disable iff (!rst_b)
      (sfr_req.rd && sfr_req.addr == ADDR_IRQ_PRIO2) |=> (sfr_rdata == $past(irq_prio_r));
  endproperty
  a_rd_prio: assert property (p_rd_prio) else $error("priority read wrong");

  // A read elsewhere must not echo either register
  property p_rd_other;
    @(posedge sys_clk) disable iff (!rst_b)
      (sfr_req.rd && !sfr_hit) |=> (sfr_rdata == 8'h00_00);
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("foreign read data");

  // Scan-end goes to exactly the level its priority bit names
  property p_scan_end_level;
    @(posedge sys_clk) disable iff (!rst_b)
      masked[6] |-> (high_req[6] == irq_prio_r[6]) && (low_req[6] == !irq_prio_r[6]);
  endproperty
  a_scan_end_level: assert property (p_scan_end_level) else $error("scan-end level");

  // Comparator goes to exactly the level its priority bit names
  property p_cmp_level;
    @(posedge sys_clk) disable iff (!rst_b)
      masked[5] |-> (high_req[5] == irq_prio_r[5]) && (low_req[5] == !irq_prio_r[5]);
  endproperty
  a_cmp_level: assert property (p_cmp_level) else $error("comparator level");

  // Conversion-done goes to exactly the level its priority bit names
  property p_done_level;
    @(posedge sys_clk) disable iff (!rst_b)
      masked[4] |-> (high_req[4] == irq_prio_r[4]) && (low_req[4] == !irq_prio_r[4]);
  endproperty
  a_done_level: assert property (p_done_level) else $error("done level");

  // Oscillator-fail goes to exactly the level its priority bit names
  property p_rtc_level;
    @(posedge sys_clk) disable iff (!rst_b)
      masked[2] |-> (high_req[2] == irq_prio_r[2]) && (low_req[2] == !irq_prio_r[2]);
  endproperty
  a_rtc_level: assert property (p_rtc_level) else $error("osc-fail level");

  // Port match goes to exactly the level its priority bit names
  property p_match_level;
    @(posedge sys_clk) disable iff (!rst_b)
      masked[1] |-> (high_req[1] == irq_prio_r[1]) && (low_req[1] == !irq_prio_r[1]);
  endproperty
  a_match_level: assert property (p_match_level) else $error("match level");

  // Supply warning goes to exactly the level its priority bit names
  property p_supply_level;
    @(posedge sys_clk) disable iff (!rst_b)
      masked[0] |-> (high_req[0] == irq_prio_r[0]) && (low_req[0] == !irq_prio_r[0]);
  endproperty
  a_supply_level: assert property (p_supply_level) else $error("supply level");

  // Any routine in service holds the low level off
  property p_low_held;
    @(posedge sys_clk) disable iff (!rst_b)
      (in_high_isr || in_low_isr) |=> !irq_low;
  endproperty
  a_low_held: assert property (p_low_held) else $error("low during service");

  // A high routine in service holds the high level off
  property p_high_held;
    @(posedge sys_clk) disable iff (!rst_b)
      in_high_isr |=> !irq_high;
  endproperty
  a_high_held: assert property (p_high_held) else $error("high nested in high");

  // A high request breaks into low service
  property p_preempt;
    @(posedge sys_clk) disable iff (!rst_b)
      ((|high_req) && in_low_isr && !in_high_isr) |=> irq_high;
  endproperty
  a_preempt: assert property (p_preempt) else $error("no preemption");

  // Only one level is ever presented at a time
  property p_one_level;
    @(posedge sys_clk) disable iff (!rst_b)
      !(irq_high && irq_low);
  endproperty
  a_one_level: assert property (p_one_level) else $error("both levels up");

  // Source code is one-hot exactly while a request is presented
  property p_src_onehot;
    @(posedge sys_clk) disable iff (!rst_b)
      $onehot0(irq_src) && ((irq_high || irq_low) == (|irq_src));
  endproperty
  a_src_onehot: assert property (p_src_onehot) else $error("source code bad");
endmodule // irq_bank2
`default_nettype wire

/* File: verilog/irq_bank2_pkg.sv */
// Package: constants, field layout and carriers for the second extended interrupt bank
// Behaviour
// - Scan-end flag raises a request only while enable bit 6 is 1.
// - Comparator flag raises a request only while enable bit 5 is 1.
// - Conversion-done flag raises a request only while enable bit 4 is 1.
// - Enable bit 2 masks the clock oscillator-fail request.
// - Enable bit 1 gates all port-match requests.
// - Enable bit 0 masks the supply early-warning request.
// - Bits 7 and 3 of both registers read zero; writes ignored.
// - Priority bit 6 sets scan-end interrupt high when 1, low when 0.
// - Priority bit 5 sets comparator interrupt high when 1, low when 0.
// - Priority bit 2 sets oscillator-fail interrupt high when 1, low when 0.
// - Priority bit 0 sets supply-warning interrupt high when 1, low when 0.
// - Enable register answers at address 0xE7 on every register page.
`default_nettype none
package irq_bank2_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_EN2   = 8'h00_E7;
  localparam logic [7:0] ADDR_IRQ_PRIO2 = 8'h00_F7;
  localparam logic [7:0] RESET_VAL      = 8'h00_00;
  // Implemented bits: 6,5,4,2,1,0; bits 7 and 3 are unused
  localparam logic [7:0] IMPL_MASK      = 8'h00_77;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_SCAN_END  = 6;
  localparam int BIT_CAP_CMP   = 5;
  localparam int BIT_CAP_DONE  = 4;
  localparam int BIT_RTC_FAIL  = 2;
  localparam int BIT_PIN_MATCH = 1;
  localparam int BIT_SUPPLY    = 0;

  // Source flags from peripherals, same layout as the registers
  typedef struct packed {
    logic       unused7;
    logic       scan_end_flag;
    logic       cap_compare_flag;
    logic       cap_done_flag;
    logic       unused3;
    logic       rtc_osc_fail_flag;
    logic       pin_match_flag;
    logic       supply_warn_flag;
  } src_flags_s;

  // Special-function register access strobe group
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;
endpackage : irq_bank2_pkg
`default_nettype wire

/* File: verilog/irq_prio_split.sv */
// Priority split of masked requests into high and low levels
`timescale 1ns/1ns
`default_nettype none
module irq_prio_split
  import irq_bank2_pkg::*;
(
  input  wire logic [7:0] masked_req,  // Enabled pending requests
  input  wire logic [7:0] prio,        // Priority register, 1 = high
  output logic      [7:0] high_req,    // High-level requests
  output logic      [7:0] low_req      // Low-level requests
);
  // -------------------------------------------------------------
  // Per-bit level selection
  // -------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bit
      // Each source goes to exactly one level
      assign high_req[gi] = masked_req[gi] & prio[gi];
      assign low_req[gi]  = masked_req[gi] & ~prio[gi];
    end
  endgenerate
endmodule // irq_prio_split
`default_nettype wire
